/* File: design/ccg_consts.vh */
// constants for the codec clock and reset generator
// assumes a 100 MHz system clock and the plain register port of ccg_top
`ifndef CCG_CONSTS_VH
`define CCG_CONSTS_VH

// register index on the plain port
`define CCG_ADR_CW0      3'h0
`define CCG_ADR_CW1      3'h1
`define CCG_ADR_CW2      3'h2
`define CCG_ADR_CW3      3'h3
`define CCG_ADR_STAT     3'h4

// ctrl_word_0 fields
`define CCG_CW0_AUXB_HI  4
`define CCG_CW0_AUXB_LO  0
// ctrl_word_1 fields
`define CCG_CW1_SEL      0
`define CCG_CW1_AUXA_HI  5
`define CCG_CW1_AUXA_LO  1
`define CCG_CW1_ADJ_HI   12
`define CCG_CW1_ADJ_LO   6
`define CCG_CW1_DIR      13
// ctrl_word_2 fields (fractional divider M, S, N)
`define CCG_CW2_M_HI     5
`define CCG_CW2_M_LO     0
`define CCG_CW2_S        6
`define CCG_CW2_N_HI     12
`define CCG_CW2_N_LO     7
// ctrl_word_3 fields
`define CCG_CW3_TRIG     0
// status fields
`define CCG_ST_RST       0
`define CCG_ST_BURST     1
`define CCG_ST_OSC       2
`define CCG_ST_EXT       3

// reset values and fractional divider constants
`define CCG_AUX_RST      5'h10
`define CCG_SEL_RST      1'h1
`define CCG_M_RST        6'h08
`define CCG_M_ZERO_VAL   7'h40
`define CCG_FRAC_DEN     8'h7d
`define CCG_SMP_LAST     7'h7c

// timing
`define CCG_CLK_MHZ      100
`define CCG_POR_MIN_US   1500
`define CCG_POR_CYC      (`CCG_POR_MIN_US * `CCG_CLK_MHZ)

`endif

/* File: design/ccg_div.v */
// programmable clock divider, 5-bit divisor, counts enable ticks
// assumes div is stable or changes only between output periods
`timescale 1ns/10ps
module ccg_div
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // control
  input  wire       en,
  input  wire       clr,
  input  wire [4:0] div,
  // clock level out
  output reg        out
);

  reg  [4:0] cnt;
  wire [5:0] half_w   = {1'b0, div} + 6'h01;
  wire [4:0] half     = half_w[5:1];
  wire       last     = (cnt >= div - 5'h01);
  wire [4:0] next_cnt = last ? 5'h00 : cnt + 5'h01;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 5'h00;
      out <= 1'b0;
    end
    else if (clr)
    begin
      // restart phase so the output lines up with the release
      cnt <= 5'h00;
      out <= (div != 5'h00);
    end
    else if (div == 5'h00)
    begin
      cnt <= 5'h00;
      out <= 1'b0;
    end
    else if (en)
    begin
      cnt <= next_cnt;
      out <= (next_cnt < half);
    end
  end

endmodule

/* File: design/ccg_top.v */
// clock and power-on reset generator of the voiceband codec
// assumes CLK stands for the selected master clock; derived clocks are
// strobes or levels on CLK, register port is on the same clock
//
// Contract
// - internal reset is power-on output OR inverted ext_reset_n; por_out_n is inverse of the power-on output only.
// - power-on output ORs internal pulse with capacitor-timed pulse from por_timing_cap.
// - writing one to por_test_trigger regenerates the internal power-on pulse.
// - osc_enable_pin high runs crystal oscillator; low powers it down, selects ext clock.
// - aux_clk_out_b is master_clk divided by aux_b_divisor; zero holds it low.
// - ext_reset_n low forces aux_b divide by 16, keeps toggling, resync on rise.
// - divided_master_clk is master_clk divided by one or two per pre_divider_sel.
// - each ctrl_word_1 write with nonzero phase_adjust_count starts one burst.
// - during burst divide one less for advance, one more for retard. Advance from divide-by-one stays at divide by one.
// - oversample, sample and aux_a clocks all derive from divided_master_clk.
// - ext_reset_n low forces pre-divider by two, keeps running, resync on rise.
// - aux_clk_out_a is divided_master_clk divided by aux_a_divisor; zero disables.
// - ext_reset_n low forces aux_a divide by 16, keeps toggling, resync on rise.
// - fractional divider keeps every sample period exactly constant except the first after reset or resync, which has one fewer long period.
// - ratio is M plus S times N over 125 with M, N, S limits.
// - sample_clk is oversample_clk divided by a fixed 125.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "ccg_consts.vh"
module ccg_top
#(
  parameter POR_PULSE_CYC = `CCG_POR_CYC
)
(
  // clock and reset
  input  wire        CLK,
  input  wire        SYS_RST,
  // pins
  input  wire        EXT_RESET_N,
  input  wire        OSC_ENABLE_PIN,
  input  wire        POR_TIMING_CAP,
  output reg         POR_OUT_N,
  output reg         OSC_RUN,
  output reg         CLK_SRC_EXT,
  // register port
  input  wire [2:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  // derived clocks
  output reg         DMC_TICK,
  output reg         OVS_TICK,
  output reg         SAMPLE_TICK,
  output wire        AUX_CLK_OUT_A,
  output wire        AUX_CLK_OUT_B
);

  // pin synchronisers: ext_reset_n, osc_enable_pin, por_timing_cap
  wire [2:0] pin_raw = {POR_TIMING_CAP, OSC_ENABLE_PIN, EXT_RESET_N};
  reg  [2:0] pin_s1;
  reg  [2:0] pin_s2;
  reg  [2:0] pin_s3;
  reg  [2:0] pin_val;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      always @(posedge CLK or posedge SYS_RST)
      begin
        if (SYS_RST)
        begin
          pin_s1[gi]  <= 1'b0;
          pin_s2[gi]  <= 1'b0;
          pin_s3[gi]  <= 1'b0;
          pin_val[gi] <= 1'b0;
        end
        else
        begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          // a change counts only once two stages agree
          if (pin_s2[gi] == pin_s3[gi])
            pin_val[gi] <= pin_s3[gi];
        end
      end
    end
  endgenerate

  wire ext_n   = pin_val[0];
  wire osc_en  = pin_val[1];
  wire cap_hi  = pin_val[2];
  reg  ext_prev;
  wire resync  = ext_n & ~ext_prev;
  wire ext_low = ~ext_n;

  // power-on pulse generator
  reg  [17:0] por_cnt;
  reg         int_rst;
  wire        trig_wr;
  wire        por_int = (por_cnt != 18'h00000);
  // the cap buffer inverts: pin still low means the cap is charging
  wire        por_gen = por_int | ~cap_hi;

  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      por_cnt   <= POR_PULSE_CYC[17:0];
      int_rst   <= 1'b1;
      POR_OUT_N <= 1'b0;
      ext_prev  <= 1'b0;
    end
    else
    begin
      if (trig_wr)
        por_cnt <= POR_PULSE_CYC[17:0];
      else if (por_int)
        por_cnt <= por_cnt - 18'h00001;
      int_rst   <= por_gen | ~ext_n;
      POR_OUT_N <= ~por_gen;
      ext_prev  <= ext_n;
    end
  end

  // oscillator control
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      OSC_RUN     <= 1'b0;
      CLK_SRC_EXT <= 1'b1;
    end
    else
    begin
      OSC_RUN     <= osc_en;
      CLK_SRC_EXT <= ~osc_en;
    end
  end

  // control registers, returned to defaults by the internal reset
  reg [4:0] aux_b_divisor;
  reg [4:0] aux_a_divisor;
  reg       pre_divider_sel;
  reg       phase_adjust_dir;
  reg [5:0] frac_m;
  reg       frac_s;
  reg [5:0] frac_n;
  reg [6:0] burst_cnt;
  wire      pre_wrap;

  wire [6:0] adj_w  = WDATA[`CCG_CW1_ADJ_HI:`CCG_CW1_ADJ_LO];
  wire       cw1_wr = WR & (ADDR == `CCG_ADR_CW1);
  assign trig_wr = WR & (ADDR == `CCG_ADR_CW3) & WDATA[`CCG_CW3_TRIG];

  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      aux_b_divisor    <= `CCG_AUX_RST;
      aux_a_divisor    <= `CCG_AUX_RST;
      pre_divider_sel  <= `CCG_SEL_RST;
      phase_adjust_dir <= 1'b0;
      frac_m           <= `CCG_M_RST;
      frac_s           <= 1'b0;
      frac_n           <= 6'h00;
      burst_cnt        <= 7'h00;
    end
    else if (int_rst)
    begin
      // fields only; divider counters below keep running
      aux_b_divisor    <= `CCG_AUX_RST;
      aux_a_divisor    <= `CCG_AUX_RST;
      pre_divider_sel  <= `CCG_SEL_RST;
      phase_adjust_dir <= 1'b0;
      frac_m           <= `CCG_M_RST;
      frac_s           <= 1'b0;
      frac_n           <= 6'h00;
      burst_cnt        <= 7'h00;
    end
    else
    begin
      if (WR & (ADDR == `CCG_ADR_CW0))
        aux_b_divisor <= WDATA[`CCG_CW0_AUXB_HI:`CCG_CW0_AUXB_LO];
      if (cw1_wr)
      begin
        pre_divider_sel  <= WDATA[`CCG_CW1_SEL];
        aux_a_divisor    <= WDATA[`CCG_CW1_AUXA_HI:`CCG_CW1_AUXA_LO];
        phase_adjust_dir <= WDATA[`CCG_CW1_DIR];
      end
      if (WR & (ADDR == `CCG_ADR_CW2))
      begin
        frac_m <= WDATA[`CCG_CW2_M_HI:`CCG_CW2_M_LO];
        frac_s <= WDATA[`CCG_CW2_S];
        frac_n <= WDATA[`CCG_CW2_N_HI:`CCG_CW2_N_LO];
      end
      // a zero count leaves any running burst alone
      if (cw1_wr && adj_w != 7'h00)
        burst_cnt <= adj_w;
      else if (pre_wrap && burst_cnt != 7'h00)
        burst_cnt <= burst_cnt - 7'h01;
    end
  end

  // read port, data valid the cycle after the strobe
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      RDATA <= 16'h0000;
    else if (RD)
    begin
      case (ADDR)
        `CCG_ADR_CW0:
          RDATA <= {11'h000, aux_b_divisor};
        `CCG_ADR_CW1:
          RDATA <= {2'h0, phase_adjust_dir, burst_cnt, aux_a_divisor,
                    pre_divider_sel};
        `CCG_ADR_CW2:
          RDATA <= {3'h0, frac_n, frac_s, frac_m};
        `CCG_ADR_STAT:
          RDATA <= {12'h000, ext_n, osc_en, (burst_cnt != 7'h00), int_rst};
        default:
          RDATA <= 16'h0000;
      endcase
    end
    else
      RDATA <= 16'h0000;
  end

  // pre-divider
  reg  [1:0] pre_cnt;
  reg  [1:0] pre_eff;
  wire       sel_eff = ext_low | pre_divider_sel;
  wire [1:0] pre_base = sel_eff ? 2'h2 : 2'h1;

  always @*
  begin
    pre_eff = pre_base;
    if (burst_cnt != 7'h00)
      pre_eff = phase_adjust_dir ? pre_base - 2'h1 : pre_base + 2'h1;
    // advance from divide-by-one is not allowed; never stop the clock
    if (pre_eff == 2'h0)
      pre_eff = 2'h1;
  end

  assign pre_wrap = (pre_cnt >= pre_eff - 2'h1);

  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pre_cnt  <= 2'h0;
      DMC_TICK <= 1'b0;
    end
    else if (resync)
    begin
      pre_cnt  <= 2'h0;
      DMC_TICK <= 1'b0;
    end
    else
    begin
      pre_cnt  <= pre_wrap ? 2'h0 : pre_cnt + 2'h1;
      DMC_TICK <= pre_wrap;
    end
  end

  // fractional divider: N periods of M plus one (M minus one with S when M is above 2; none when M is 1) spread evenly over 125
  wire [6:0] m_val  = (frac_m == 6'h00) ? `CCG_M_ZERO_VAL : {1'b0, frac_m};
  wire       m_one  = (m_val == 7'h01);
  wire       s_neg  = frac_s & (m_val > 7'h02);
  wire [5:0] n_eff  = m_one ? 6'h00 : frac_n;
  wire [6:0] m_alt  = s_neg ? m_val - 7'h01 : m_val + 7'h01;
  reg  [6:0] os_cnt;
  reg  [6:0] smp_cnt;
  reg  [7:0] acc;
  reg        use_alt;
  wire [6:0] cur_per = use_alt ? m_alt : m_val;
  wire       os_wrap  = (os_cnt + 7'h01 >= cur_per);
  wire       smp_wrap = (smp_cnt == `CCG_SMP_LAST);
  // restarting the spread at each sample keeps that period exact
  wire [7:0] acc_sum = (smp_wrap ? 8'h00 : acc) + {2'h0, n_eff};
  wire       next_alt = (acc_sum >= `CCG_FRAC_DEN);

  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      os_cnt      <= 7'h00;
      smp_cnt     <= 7'h00;
      acc         <= 8'h00;
      use_alt     <= 1'b0;
      OVS_TICK    <= 1'b0;
      SAMPLE_TICK <= 1'b0;
    end
    else if (resync)
    begin
      os_cnt      <= 7'h00;
      smp_cnt     <= 7'h00;
      acc         <= 8'h00;
      use_alt     <= 1'b0;
      OVS_TICK    <= 1'b0;
      SAMPLE_TICK <= 1'b0;
    end
    else
    begin
      OVS_TICK    <= DMC_TICK & os_wrap;
      SAMPLE_TICK <= DMC_TICK & os_wrap & smp_wrap;
      if (DMC_TICK)
      begin
        if (os_wrap)
        begin
          os_cnt  <= 7'h00;
          smp_cnt <= smp_wrap ? 7'h00 : smp_cnt + 7'h01;
          acc     <= next_alt ? acc_sum - `CCG_FRAC_DEN : acc_sum;
          use_alt <= next_alt;
        end
        else
          os_cnt <= os_cnt + 7'h01;
      end
    end
  end

  // output clock dividers; forced to 16 while ext_reset_n is low
  wire [4:0] aux_a_eff = ext_low ? `CCG_AUX_RST : aux_a_divisor;
  wire [4:0] aux_b_eff = ext_low ? `CCG_AUX_RST : aux_b_divisor;

  ccg_div u_aux_a
  (
    .clk (CLK),
    .rst (SYS_RST),
    .en  (DMC_TICK),
    .clr (resync),
    .div (aux_a_eff),
    .out (AUX_CLK_OUT_A)
  );

  ccg_div u_aux_b
  (
    .clk (CLK),
    .rst (SYS_RST),
    .en  (1'b1),
    .clr (resync),
    .div (aux_b_eff),
    .out (AUX_CLK_OUT_B)
  );

endmodule

/* File: verif/ccg_board_model.sv */
// board model: resistor and capacitor on the power-on timing pin
// assumes sys_rst stands for power coming up
`timescale 1ns/10ps
module ccg_board_model
#(
  parameter CAP_CYC = 60
)
(
  input  wire clk,
  input  wire sys_rst,
  output reg  cap
);
  integer t;
  // charging outlasts the internal pulse, so the pin alone stretches it
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      t <= 0;
      cap <= 1'b0;
    end
    else
    begin
      t <= (t < CAP_CYC) ? t + 1 : t;
      cap <= (t >= CAP_CYC - 1);
    end
endmodule

/* File: verif/ccg_top_props.sv */
// port checker for ccg_top
// assumes the bound pulse length matches the design parameter
`timescale 1ns/10ps
module ccg_top_props
#(
  parameter POR_PULSE_CYC = 20
)
(
  input wire        CLK,
  input wire        SYS_RST,
  input wire        EXT_RESET_N,
  input wire        OSC_ENABLE_PIN,
  input wire        POR_TIMING_CAP,
  input wire        POR_OUT_N,
  input wire        OSC_RUN,
  input wire        CLK_SRC_EXT,
  input wire        RD,
  input wire [15:0] RDATA,
  input wire        DMC_TICK,
  input wire        OVS_TICK,
  input wire        SAMPLE_TICK,
  input wire        AUX_CLK_OUT_A,
  input wire        AUX_CLK_OUT_B
);
  reg [31:0] por_lo_cnt;
  reg [5:0]  ext_lo_cnt;
  // low-time counters stand in for long repetitions
  always @(posedge CLK or posedge SYS_RST)
    if (SYS_RST)
    begin
      por_lo_cnt <= 32'h0;
      ext_lo_cnt <= 6'h0;
    end
    else
    begin
      por_lo_cnt <= POR_OUT_N ? 32'h0 : por_lo_cnt + 32'h1;
      ext_lo_cnt <= EXT_RESET_N ? 6'h0 : ext_lo_cnt + {5'h0, ~&ext_lo_cnt};
    end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_por_width:
    assert property ($rose(POR_OUT_N) |-> por_lo_cnt >= POR_PULSE_CYC)
    else $error("power-on pulse too short");
  a_cap_holds:
    assert property ($rose(POR_OUT_N) |-> $past(POR_TIMING_CAP, 3))
    else $error("power-on ended while timing pin low");
  a_osc_excl:
    assert property (OSC_RUN != CLK_SRC_EXT)
    else $error("oscillator and external clock both chosen");
  a_osc_follow:
    assert property ($stable(OSC_ENABLE_PIN) [*8] |-> OSC_RUN == OSC_ENABLE_PIN)
    else $error("oscillator run does not follow its pin");
  a_rdata_idle:
    assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside its cycle");
  a_dmc_forced:
    assert property (ext_lo_cnt > 6'd20 && DMC_TICK |=> !DMC_TICK ##1 DMC_TICK)
    else $error("pre-divider not by two in external reset");
  a_auxb_forced:
    assert property ($rose(AUX_CLK_OUT_B) && ext_lo_cnt > 6'd30 |->
      $past(AUX_CLK_OUT_B, 16) && $past(AUX_CLK_OUT_B, 9) &&
      !$past(AUX_CLK_OUT_B, 8))
    else $error("aux b not by 16 in external reset");
  a_auxa_forced:
    assert property ($rose(AUX_CLK_OUT_A) && ext_lo_cnt > 6'd50 |->
      $past(AUX_CLK_OUT_A, 32) && $past(AUX_CLK_OUT_A, 17) &&
      !$past(AUX_CLK_OUT_A, 16))
    else $error("aux a not by 16 in external reset");
  a_sample_ovs:
    assert property (SAMPLE_TICK |-> OVS_TICK)
    else $error("sample tick off the oversample grid");
endmodule
bind ccg_top ccg_top_props #(.POR_PULSE_CYC(POR_PULSE_CYC)) u_props (
  .CLK(CLK), .SYS_RST(SYS_RST), .EXT_RESET_N(EXT_RESET_N),
  .OSC_ENABLE_PIN(OSC_ENABLE_PIN), .POR_TIMING_CAP(POR_TIMING_CAP),
  .POR_OUT_N(POR_OUT_N), .OSC_RUN(OSC_RUN), .CLK_SRC_EXT(CLK_SRC_EXT),
  .RD(RD), .RDATA(RDATA), .DMC_TICK(DMC_TICK), .OVS_TICK(OVS_TICK),
  .SAMPLE_TICK(SAMPLE_TICK), .AUX_CLK_OUT_A(AUX_CLK_OUT_A),
  .AUX_CLK_OUT_B(AUX_CLK_OUT_B));

/* File: verif/ccg_top_tb.sv */
// self-checking bench for ccg_top over its register port and pins
// assumes a 100 MHz clock and a shortened power-on pulse
`timescale 1ns/10ps
module ccg_top_tb;
  reg          clk = 1'b0;
  reg          sys_rst = 1'b1;
  reg          ext_n = 1'b1;
  reg          osc_en = 1'b1;
  reg  [2:0]   addr = 3'h0;
  reg  [15:0]  wdata = 16'h0;
  reg          wr = 1'b0;
  reg          rd = 1'b0;
  wire         cap, por_n, osc_run, src_ext, dmc, ovs, smp, aux_a, aux_b;
  wire [15:0]  rdata;
  wire [4:0]   mon = {ovs, smp, dmc, aux_a, aux_b};
  integer      miscompares = 0;
  integer      cmp_count = 0;
  int          p, h, a, b, i;
  logic [15:0] v;
  logic [15:0] rst_tab [6] = '{16'h10, 16'h21, 16'h8, 16'h0, 16'hc, 16'h0};
  logic [15:0] frac_tab [3] = '{16'h02c3, 16'h1f42, 16'h02c1};
  logic [15:0] per_tab [3] = '{16'd740, 16'd624, 16'd250};
  always #5 clk = ~clk;
  ccg_top #(.POR_PULSE_CYC(20)) dut_u (.CLK(clk), .SYS_RST(sys_rst),
    .EXT_RESET_N(ext_n), .OSC_ENABLE_PIN(osc_en), .POR_TIMING_CAP(cap),
    .POR_OUT_N(por_n), .OSC_RUN(osc_run), .CLK_SRC_EXT(src_ext),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .DMC_TICK(dmc), .OVS_TICK(ovs), .SAMPLE_TICK(smp),
    .AUX_CLK_OUT_A(aux_a), .AUX_CLK_OUT_B(aux_b));
  ccg_board_model #(.CAP_CYC(60)) board_u (.clk(clk), .sys_rst(sys_rst),
    .cap(cap));
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wr_reg(input [2:0] ad, input [15:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [2:0] ad, output [15:0] d);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // polls the internal reset flag, reads are served during reset
  task ready;
    int j;
    v = 16'h1;
    for (j = 0; j < 60 && v[0] !== 1'b0; j++)
      rd_reg(3'h4, v);
    chk("reset done", {15'h0, v[0]}, 16'h0);
  endtask
  task chk_rst(input int n);
    for (i = 0; i < n; i++)
    begin
      rd_reg(i[2:0], v);
      chk("reset value", v, rst_tab[i]);
    end
  endtask
  // second full period; the first may straddle a divisor change
  task meas(input int k, output int per, output int hi);
    int n, c;
    logic pv;
    n = 0;
    c = 0;
    pv = 1'b1;
    per = 0;
    hi = 0;
    while (n < 3 && c < 5000)
    begin
      @(posedge clk);
      #1 c++;
      n += (mon[k] && !pv);
      per += (n == 2);
      hi += (n == 2 && mon[k]);
      pv = mon[k];
    end
  endtask
  task cnt(input int k, input int cyc, output int t);
    t = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      #1 t += mon[k];
    end
  endtask
  // write aligned to a divided tick so every run sees the same phase
  task burst(input [15:0] w, output int t);
    int c;
    c = 0;
    do
    begin
      @(posedge clk);
      #1 c++;
    end
    while (dmc !== 1'b1 && c < 9);
    wr_reg(3'h1, w);
    cnt(2, 60, t);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (40) @(posedge clk);
    #1 chk("cap stretch", {15'h0, por_n}, 16'h0);
    ready;
    chk_rst(6);
    wr_reg(3'h0, 16'h0005);
    meas(0, p, h);
    chk("aux b div5", {p[7:0], h[7:0]}, 16'h0503);
    wr_reg(3'h0, 16'h0000);
    cnt(0, 10, p);
    cnt(0, 40, p);
    chk("aux b off", 16'(p), 16'd0);
    wr_reg(3'h1, 16'h0006);
    meas(1, p, h);
    chk("aux a div1", {p[7:0], h[7:0]}, 16'h0302);
    cnt(2, 20, p);
    chk("dmc div1", 16'(p), 16'd20);
    wr_reg(3'h1, 16'h0007);
    meas(1, p, h);
    chk("aux a div2", {p[7:0], h[7:0]}, 16'h0604);
    cnt(2, 20, p);
    chk("dmc div2", 16'(p), 16'd10);
    burst(16'h0021, b);
    burst(16'h2221, a);
    chk("advance gain", 16'(a - b), 16'd4);
    burst(16'h0221, a);
    chk("retard loss", 16'(b - a), 16'd4);
    wr_reg(3'h1, 16'h0221);
    rd_reg(3'h4, v);
    chk("burst status", v, 16'h000e);
    for (i = 0; i < 3; i++)
    begin
      wr_reg(3'h2, frac_tab[i]);
      meas(3, p, h);
      chk("sample period", 16'(p), per_tab[i]);
    end
    cnt(4, 20, p);
    chk("ovs m1", 16'(p), 16'd10);
    @(posedge clk) osc_en <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk("osc off", {14'h0, osc_run, src_ext}, 16'h1);
    @(posedge clk) osc_en <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk("osc on", {14'h0, osc_run, src_ext}, 16'h2);
    @(posedge clk) ext_n <= 1'b0;
    repeat (10) @(posedge clk);
    rd_reg(3'h4, v);
    chk("ext status", v, 16'h0005);
    chk("por pin idle", {15'h0, por_n}, 16'h1);
    repeat (80) @(posedge clk);
    ext_n <= 1'b1;
    ready;
    chk_rst(3);
    wr_reg(3'h0, 16'h0003);
    wr_reg(3'h3, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk("test pulse", {15'h0, por_n}, 16'h0);
    ready;
    chk_rst(3);
    wrap_up;
  end
  initial
  begin
    #300000;
    miscompares++;
    wrap_up;
  end
endmodule
